// file: core/dma_ctrl_pkg.sv
// Constants and types shared by the DMA channel control block
package dma_ctrl_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DMA_CYCLE_NS = 30;
    // Least time, so round up; never below one cycle
    localparam int CYCLE_CLKS_RAW = (DMA_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_CLKS = (CYCLE_CLKS_RAW < 1) ? 1 : CYCLE_CLKS_RAW;
    localparam logic [3:0] CYCLE_LAST = 4'(CYCLE_CLKS - 1);

    // ----------------------------------------------------------------
    // Request source select field in the pointers
    // ----------------------------------------------------------------
    localparam int SEL_LO = 16;
    localparam int SEL_HI = 17;
    localparam logic [1:0] SEL_EXT = 2'h0;
    localparam logic [1:0] SEL_SER0 = 2'h1;
    localparam logic [1:0] SEL_SER1 = 2'h2;
    localparam logic [1:0] SEL_RSVD = 2'h3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic ENABLE_RST = 1'b0;
    localparam logic [1:0] SYNC_RST = 2'h0;

    typedef enum logic [1:0] {
        MODE_MEM_BURST = 2'b00,
        MODE_MEM_STEAL = 2'b01,
        MODE_MEM_IO = 2'b10,
        MODE_MMIO = 2'b11
    } xfer_mode_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_CYCLE = 2'b01
    } cycle_state_t;

endpackage : dma_ctrl_pkg

// file: core/byte_counter.sv
// Per-channel transfer byte counter; a loaded zero means a full 64 kB
module byte_counter
#(
    parameter int COUNT_W = 16
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [COUNT_W-1:0] load_value,
    input wire logic step,
    output logic [COUNT_W:0] remaining,
    output logic last
);
    logic [COUNT_W:0] remaining_q;
    logic [COUNT_W:0] remaining_d;

    initial
    begin
        if (COUNT_W < 1) $error("byte_counter: COUNT_W must be at least 1");
    end

    always_comb
    begin
        remaining_d = remaining_q;
        if (load)
        begin
            // Zero count is the largest transfer, not an empty one
            remaining_d = (load_value == '0) ? {1'b1, {COUNT_W{1'b0}}}
                                             : {1'b0, load_value};
        end
        else if (step && remaining_q != '0)
        begin
            remaining_d = remaining_q - {{COUNT_W{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            remaining_q <= '0;
        else
            remaining_q <= remaining_d;
    end

    assign remaining = remaining_q;
    assign last = (remaining_q == {{COUNT_W{1'b0}}, 1'b1});

endmodule : byte_counter

// file: core/dma_channel_control.sv
// Two-channel DMA control: enables, guards, master enable, arbitration, request select
//
// Behaviour
// - Cleared channel enable stops that channel's transfers
// - Enable runs channel; guard gates software writes
// - Memory burst uninterruptible; other modes yield between cycles
// - NMI clears master at once; the current cycle still completes
// - Writing enable one also sets master enable
// - External request only when select bits zero
// - Source bits 17:16 pick receive-full request source
// - Target bits 17:16 pick transmit-empty request source
// - Channel 1 ignored during channel 0 memory transfer
// - Zero byte count transfers full 64 kB
module dma_channel_control
    import dma_ctrl_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int COUNT_W = 16
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic cpu_wr,
    input wire logic wr_chan_zero_on,
    input wire logic wr_chan_one_on,
    input wire logic wr_write_guard,
    input wire logic wr_chan_one_write_guard,
    input wire logic nmi,
    input wire logic ext_request_zero,
    input wire logic receive_full_flag0,
    input wire logic receive_full_flag1,
    input wire logic transmit_empty_flag0,
    input wire logic transmit_empty_flag1,
    input wire logic chan_one_request,
    input wire dma_ctrl_pkg::xfer_mode_t chan_zero_mode,
    input wire logic chan_zero_io_is_source,
    input wire logic [ADDR_W-1:0] source_pointer,
    input wire logic [ADDR_W-1:0] target_pointer,
    input wire logic [COUNT_W-1:0] count_zero,
    input wire logic [COUNT_W-1:0] count_one,
    input wire logic cpu_bus_request,
    output logic chan_zero_on,
    output logic chan_one_on,
    output logic master_on,
    output logic dma_cycle,
    output logic cycle_chan,
    output logic cycle_end,
    output logic cpu_bus_grant
);
    import dma_ctrl_pkg::*;

    initial
    begin
        if (ADDR_W <= SEL_HI) $error("dma_channel_control: ADDR_W too small");
        if (COUNT_W < 1) $error("dma_channel_control: COUNT_W too small");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers: three stages, change accepted when 2 and 3 agree
    // ----------------------------------------------------------------
    logic [2:0] nmi_s_q;
    logic [2:0] ext_s_q;
    logic nmi_f_q;
    logic nmi_f_d;
    logic ext_f_q;
    logic ext_f_d;
    logic nmi_evt;

    always_comb
    begin
        nmi_f_d = (nmi_s_q[1] == nmi_s_q[2]) ? nmi_s_q[2] : nmi_f_q;
        ext_f_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_f_q;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            nmi_s_q <= '0;
            ext_s_q <= '0;
            nmi_f_q <= 1'b0;
            ext_f_q <= 1'b0;
        end
        else
        begin
            nmi_s_q <= {nmi_s_q[1:0], nmi};
            ext_s_q <= {ext_s_q[1:0], ext_request_zero};
            nmi_f_q <= nmi_f_d;
            ext_f_q <= ext_f_d;
        end
    end

    // Edge-triggered: a held NMI must not keep master enable pinned low
    assign nmi_evt = nmi_f_d & ~nmi_f_q;

    // ----------------------------------------------------------------
    // Channel 0 request source select
    // ----------------------------------------------------------------
    logic [1:0] ch0_sel;
    logic ch0_io_req;
    logic ch0_request;
    logic ch0_is_mem;

    always_comb
    begin
        // Bit 18 and above play no part in the choice
        ch0_sel = chan_zero_io_is_source ? source_pointer[SEL_HI:SEL_LO]
                                         : target_pointer[SEL_HI:SEL_LO];
        case (ch0_sel)
            // Pin honoured only with both select bits clear
            SEL_EXT: ch0_io_req = ext_f_q;
            SEL_SER0: ch0_io_req = chan_zero_io_is_source ? receive_full_flag0
                                                          : transmit_empty_flag0;
            SEL_SER1: ch0_io_req = chan_zero_io_is_source ? receive_full_flag1
                                                          : transmit_empty_flag1;
            default: ch0_io_req = 1'b0;
        endcase
        ch0_is_mem = (chan_zero_mode == MODE_MEM_BURST) || (chan_zero_mode == MODE_MEM_STEAL);
        // Memory-to-memory needs no peripheral request
        ch0_request = ch0_is_mem ? 1'b1 : ch0_io_req;
    end

    // ----------------------------------------------------------------
    // Enables and cycle engine
    // ----------------------------------------------------------------
    cycle_state_t state_q;
    cycle_state_t state_d;
    logic [3:0] tick_q;
    logic [3:0] tick_d;
    logic chan_q;
    logic chan_d;
    logic de0_q;
    logic de0_d;
    logic de1_q;
    logic de1_d;
    logic dme_q;
    logic dme_d;
    logic end_q;
    logic end_d;
    logic cyc_last;
    logic ch0_ready;
    logic ch1_ready;
    logic ch0_memmem_active;
    logic burst_hold;
    logic may_start;
    logic start;
    logic load0;
    logic load1;
    logic [COUNT_W:0] rem0;
    logic [COUNT_W:0] rem1;
    logic last0;
    logic last1;
    logic fin0;
    logic fin1;

    assign cyc_last = (state_q == S_CYCLE) && (tick_q == CYCLE_LAST);
    assign fin0 = cyc_last && !chan_q && last0;
    assign fin1 = cyc_last && chan_q && last1;
    // Guard bit low lets this write change the enable
    assign load0 = cpu_wr && !wr_write_guard && wr_chan_zero_on;
    assign load1 = cpu_wr && !wr_chan_one_write_guard && wr_chan_one_on;

    always_comb
    begin
        // Disabled channels never request
        ch0_ready = de0_q && dme_q && ch0_request;
        ch0_memmem_active = de0_q && dme_q && ch0_is_mem;
        // Channel 1 ignored while channel 0 moves memory
        ch1_ready = de1_q && dme_q && chan_one_request && !ch0_memmem_active;
        // Burst memory transfers keep the bus against the CPU
        burst_hold = ch0_memmem_active && (chan_zero_mode == MODE_MEM_BURST);
        may_start = (ch0_ready || ch1_ready) && (burst_hold || !cpu_bus_request);
        start = may_start && ((state_q == S_IDLE) || (cyc_last && !fin0 && !fin1));

        state_d = state_q;
        tick_d = tick_q;
        chan_d = chan_q;
        end_d = cyc_last;
        // A started cycle always runs to its end, NMI or not
        if (start)
        begin
            state_d = S_CYCLE;
            tick_d = '0;
            chan_d = !ch0_ready;
        end
        else if (cyc_last)
        begin
            state_d = S_IDLE;
            tick_d = '0;
        end
        else if (state_q == S_CYCLE)
        begin
            tick_d = tick_q + 4'h1;
        end

        de0_d = de0_q;
        de1_d = de1_q;
        dme_d = dme_q;
        if (fin0) de0_d = 1'b0;
        if (fin1) de1_d = 1'b0;
        if (cpu_wr && !wr_write_guard) de0_d = wr_chan_zero_on;
        if (cpu_wr && !wr_chan_one_write_guard) de1_d = wr_chan_one_on;
        // Writing a channel enable to one restarts the master
        if (load0 || load1) dme_d = 1'b1;
        // NMI takes precedence over a simultaneous restart
        if (nmi_evt) dme_d = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= S_IDLE;
            tick_q <= '0;
            chan_q <= 1'b0;
            end_q <= 1'b0;
            // Nothing runs before software sets up a channel
            de0_q <= ENABLE_RST;
            de1_q <= ENABLE_RST;
            dme_q <= ENABLE_RST;
        end
        else
        begin
            state_q <= state_d;
            tick_q <= tick_d;
            chan_q <= chan_d;
            end_q <= end_d;
            de0_q <= de0_d;
            de1_q <= de1_d;
            dme_q <= dme_d;
        end
    end

    byte_counter #(.COUNT_W(COUNT_W)) u_count_zero (
        .clk(clk),
        .srst(srst),
        .load(load0),
        .load_value(count_zero),
        .step(cyc_last && !chan_q),
        .remaining(rem0),
        .last(last0)
    );

    byte_counter #(.COUNT_W(COUNT_W)) u_count_one (
        .clk(clk),
        .srst(srst),
        .load(load1),
        .load_value(count_one),
        .step(cyc_last && chan_q),
        .remaining(rem1),
        .last(last1)
    );

    assign chan_zero_on = de0_q;
    assign chan_one_on = de1_q;
    assign master_on = dme_q;
    assign dma_cycle = (state_q == S_CYCLE);
    assign cycle_chan = chan_q;
    assign cycle_end = end_q;
    assign cpu_bus_grant = cpu_bus_request && (state_q == S_IDLE);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_cycle_body;
        dma_cycle [*3];
    endsequence

    a_start_needs_enable: assert property (start && !ch0_ready |-> de1_q && dme_q)
        else $error("channel 1 cycle started while disabled");
    a_guard_blocks_write: assert property (
        cpu_wr && wr_write_guard && !fin0 |=> de0_q == $past(de0_q))
        else $error("guarded write changed channel 0 enable");
    a_ch0_start_enabled: assert property (start && ch0_ready |-> de0_q && dme_q)
        else $error("channel 0 cycle started while disabled");
    a_burst_keeps_bus: assert property (
        cyc_last && !chan_q && burst_hold && !fin0 && ch0_ready |=> dma_cycle)
        else $error("burst memory transfer gave up the bus");
    a_steal_yields_bus: assert property (
        cyc_last && cpu_bus_request && !burst_hold |=> !dma_cycle ##0 cpu_bus_grant)
        else $error("interruptible transfer kept the bus");
    a_nmi_clears_master: assert property (nmi_evt |=> !dme_q)
        else $error("master enable survived NMI");
    a_cycle_completes: assert property (
        $rose(dma_cycle) |-> s_cycle_body ##1 cycle_end)
        else $error("DMA cycle cut short");
    a_write_sets_master: assert property ((load0 || load1) && !nmi_evt |=> dme_q)
        else $error("enable write did not set master enable");
    a_ext_gated: assert property (
        !ch0_is_mem && ch0_sel == SEL_RSVD |-> !ch0_request)
        else $error("reserved select produced a request");
    a_ser_select: assert property (
        !ch0_is_mem && chan_zero_io_is_source && ch0_sel == SEL_SER0
        |-> ch0_request == receive_full_flag0)
        else $error("wrong receive-full request source");
    a_tx_select: assert property (
        !ch0_is_mem && !chan_zero_io_is_source && ch0_sel == SEL_SER1
        |-> ch0_request == transmit_empty_flag1)
        else $error("wrong transmit-empty request source");
    a_ch1_blocked: assert property (ch0_memmem_active && start |-> !chan_d)
        else $error("channel 1 granted during memory transfer");
    a_zero_count_full: assert property (
        load0 && count_zero == '0 |=> rem0 == {1'b1, {COUNT_W{1'b0}}})
        else $error("zero count not taken as full transfer");
    a_reset_clears: assert property ($past(srst) |-> !dme_q && !de0_q && !de1_q)
        else $error("enables not cleared by reset");

endmodule : dma_channel_control

// file: verification/serial_peer_model.sv
// Request model of the external pin and serial port flags facing the DMA block
module serial_peer_model
(
    input wire logic clk,
    input wire logic [4:0] arm,
    input wire logic cycle_end,
    input wire logic cycle_chan,
    output logic ext_request_zero,
    output logic [3:0] ser_flags
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] req_q = 5'h00;
    logic [4:0] arm_q = 5'h00;

    // A serviced channel 0 cycle drops every flag, as the data access would
    always @(negedge clk)
    begin
        arm_q <= arm;
        if (cycle_end === 1'b1 && cycle_chan === 1'b0)
            req_q <= 5'h00;
        else if (arm !== arm_q)
            req_q <= arm;
    end

    assign ext_request_zero = req_q[0];
    assign ser_flags = req_q[4:1];
endmodule : serial_peer_model

// file: verification/dma_channel_control_bench.sv
// Self-checking bench for the DMA channel control block
module dma_channel_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dma_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cpu_wr = 1'b0;
    logic wr_zero = 1'b0, wr_one = 1'b0, guard_zero = 1'b1, guard_one = 1'b1;
    logic nmi = 1'b0, chan_one_request = 1'b0, io_src = 1'b0, bus_req = 1'b0;
    xfer_mode_t mode = MODE_MEM_BURST;
    logic [19:0] src_ptr = 20'h0_0000, dst_ptr = 20'h0_0000;
    logic [3:0] cnt0 = 4'h0, cnt1 = 4'h0;
    logic [4:0] arm = 5'h00, tgt;
    logic [1:0] sel;
    logic ext_req;
    logic [3:0] ser_flags;
    logic chan_zero_on, chan_one_on, master_on, dma_cycle, cycle_chan, cycle_end, cpu_bus_grant;
    int fails = 0, num_checks = 0, cycles = 0;
    int ends0, ends1, busy, bad;

    // Four count bits keep a full zero-count run to sixteen transfers
    dma_channel_control #(.ADDR_W(20), .COUNT_W(4)) dut_u (
        .clk(clk), .srst(srst), .cpu_wr(cpu_wr),
        .wr_chan_zero_on(wr_zero), .wr_chan_one_on(wr_one),
        .wr_write_guard(guard_zero), .wr_chan_one_write_guard(guard_one),
        .nmi(nmi), .ext_request_zero(ext_req),
        .receive_full_flag0(ser_flags[0]), .receive_full_flag1(ser_flags[1]),
        .transmit_empty_flag0(ser_flags[2]), .transmit_empty_flag1(ser_flags[3]),
        .chan_one_request(chan_one_request), .chan_zero_mode(mode),
        .chan_zero_io_is_source(io_src), .source_pointer(src_ptr),
        .target_pointer(dst_ptr), .count_zero(cnt0), .count_one(cnt1),
        .cpu_bus_request(bus_req), .chan_zero_on(chan_zero_on),
        .chan_one_on(chan_one_on), .master_on(master_on), .dma_cycle(dma_cycle),
        .cycle_chan(cycle_chan), .cycle_end(cycle_end), .cpu_bus_grant(cpu_bus_grant)
    );

    serial_peer_model peer_u (
        .clk(clk), .arm(arm), .cycle_end(cycle_end), .cycle_chan(cycle_chan),
        .ext_request_zero(ext_req), .ser_flags(ser_flags)
    );

    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            fails++;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] expected);
        num_checks++;
        if (seen !== expected)
        begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", name, expected, seen);
        end
    endtask : chk

    // One-cycle write strobe; inputs change on the falling edge only
    task automatic wr(input logic c0, input logic c1, input logic k0, input logic k1);
        @(negedge clk);
        cpu_wr = 1'b1;
        wr_zero = c0;
        wr_one = c1;
        guard_zero = k0;
        guard_one = k1;
        @(negedge clk);
        cpu_wr = 1'b0;
    endtask : wr

    task automatic run(input int n);
        ends0 = 0;
        ends1 = 0;
        busy = 0;
        bad = 0;
        repeat (n)
        begin
            @(negedge clk);
            ends0 += (cycle_end === 1'b1 && cycle_chan === 1'b0);
            ends1 += (cycle_end === 1'b1 && cycle_chan === 1'b1);
            busy += (dma_cycle === 1'b1);
            bad += (dma_cycle === 1'b1 && cpu_bus_grant !== 1'b0);
            bad += (cycle_end === 1'b1 && cycle_chan === 1'b1 && chan_zero_on !== 1'b0);
        end
    endtask : run

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk("chan_zero_on", chan_zero_on, 0);
        chk("chan_one_on", chan_one_on, 0);
        chk("master_on", master_on, 0);
        wr(1'b1, 1'b0, 1'b1, 1'b1);
        chk("guarded chan_zero_on", chan_zero_on, 0);
        chk("guarded master_on", master_on, 0);
        mode = MODE_MEM_STEAL;
        cnt0 = 4'h2;
        cnt1 = 4'h1;
        chan_one_request = 1'b1;
        wr(1'b1, 1'b1, 1'b0, 1'b0);
        chk("master_on set", master_on, 1);
        run(30);
        chk("ch0 transfers", ends0, 2);
        chk("ch1 transfers", ends1, 1);
        chk("ch1 inside ch0", bad, 0);
        chk("ch0 off at end", chan_zero_on, 0);
        wr(1'b0, 1'b1, 1'b1, 1'b1);
        run(10);
        chk("ch1 guarded rearm", ends1, 0);
        wr(1'b0, 1'b1, 1'b1, 1'b0);
        run(10);
        chk("ch1 rearmed", ends1, 1);
        cnt1 = 4'h0;
        wr(1'b0, 1'b1, 1'b1, 1'b0);
        wr(1'b0, 1'b0, 1'b1, 1'b1);
        chk("guarded clear", chan_one_on, 1);
        wr(1'b0, 1'b0, 1'b1, 1'b0);
        run(4);
        run(10);
        chk("ch1 after clear", ends1, 0);
        chan_one_request = 1'b0;
        // Burst keeps the bus from the CPU, cycle steal gives it back
        mode = MODE_MEM_BURST;
        bus_req = 1'b1;
        wr(1'b1, 1'b0, 1'b0, 1'b1);
        run(20);
        chk("burst ignores cpu", ends0, 2);
        chk("grant in cycle", bad, 0);
        chk("busy clocks", busy, 6);
        mode = MODE_MEM_STEAL;
        wr(1'b1, 1'b0, 1'b0, 1'b1);
        run(20);
        chk("steal yields", ends0, 0);
        chk("cpu_bus_grant", cpu_bus_grant, 1);
        // CPU asks again inside the first cycle: that cycle ends, then the bus goes over
        bus_req = 1'b0;
        run(2);
        bus_req = 1'b1;
        run(20);
        chk("steal one cycle", ends0, 1);
        chk("grant after cycle", cpu_bus_grant, 1);
        bus_req = 1'b0;
        run(20);
        chk("steal resumes", ends0, 1);
        mode = MODE_MEM_BURST;
        cnt0 = 4'h0;
        wr(1'b1, 1'b0, 1'b0, 1'b1);
        run(60);
        chk("zero count", ends0, 16);
        chk("ch0 off at count", chan_zero_on, 0);
        wr(1'b1, 1'b0, 1'b0, 1'b1);
        run(6);
        nmi = 1'b1;
        run(10);
        chk("master after nmi", master_on, 0);
        run(20);
        chk("stopped after nmi", busy, 0);
        chk("ch0 kept on", chan_zero_on, 1);
        nmi = 1'b0;
        wr(1'b0, 1'b1, 1'b1, 1'b0);
        chk("master by ch1", master_on, 1);
        run(10);
        chk("resumed", busy != 0, 1);
        wr(1'b0, 1'b0, 1'b0, 1'b0);
        run(6);
        // Each select code on each pointer, with the other pointer pointing elsewhere
        mode = MODE_MEM_IO;
        cnt0 = 4'h1;
        for (int s = 0; s < 8; s++)
        begin
            io_src = s[2];
            sel = s[1:0];
            src_ptr = {2'b01, io_src ? sel : ~sel, 16'h0000};
            dst_ptr = {2'b01, io_src ? ~sel : sel, 16'h0000};
            tgt = (sel == 2'h0) ? 5'h01 : (sel == 2'h3) ? 5'h1f : 5'h01 << (sel + (io_src ? 0 : 2));
            arm = ~tgt & 5'h1f;
            wr(1'b1, 1'b0, 1'b0, 1'b1);
            run(10);
            chk("wrong source", ends0, 0);
            arm = tgt;
            run(12);
            chk("selected source", ends0, sel != 2'h3);
            arm = 5'h00;
            wr(1'b0, 1'b0, 1'b0, 1'b1);
            // The pin synchroniser still holds a dropped request for a few clocks
            run(6);
        end
        results();
    end
endmodule : dma_channel_control_bench
